// ---- shared/pgt_defines.svh ----
// Offsets, field positions, reset values and timing counts of the paired timer control.
`ifndef PGT_DEFINES_SVH
`define PGT_DEFINES_SVH
`define PGT_OFS_CTRL_A 12'h000
`define PGT_OFS_CTRL_B 12'h004
`define PGT_OFS_TIMER_A 12'h008
`define PGT_OFS_TIMER_B 12'h00C
`define PGT_OFS_PERIOD_A 12'h010
`define PGT_OFS_PERIOD_B 12'h014
`define PGT_BIT_RUN 15
`define PGT_BIT_IDLE_HALT 13
`define PGT_BIT_GATE 6
`define PGT_BIT_PS_HI 5
`define PGT_BIT_PS_LO 4
`define PGT_BIT_CONCAT 3
`define PGT_BIT_CSRC 1
`define PGT_CTRL_MASK 16'hA07A
`define PGT_CTRL_RESET 16'h0000
`define PGT_PERIOD_RESET 16'hFFFF
`define PGT_DIV8 8'h07
`define PGT_DIV64 8'h3F
`define PGT_DIV256 8'hFF
`endif

// ---- shared/pgt_pkg.sv ----
// Types shared by the paired timer control.
package pgt_pkg;
  typedef enum logic [1:0] {
    PGT_PS_1,
    PGT_PS_8,
    PGT_PS_64,
    PGT_PS_256
  } pgt_prescale_t;
endpackage

// ---- core/pgt_timer_pair.sv ----
// Paired 16/32-bit general timer with its control words on an AHB-Lite slave.
`include "pgt_defines.svh"

// ----------------------------------------------------------------------------
// Paired timer core and register slave
// ----------------------------------------------------------------------------
// Operation
// - Concatenated pair: run bit starts and stops the combined 32-bit counter.
// - Separate: run bit starts and stops this timer as a 16-bit counter.
// - Idle-halt select set stops counting in idle; clear keeps counting.
// - External clock source makes the gated-accumulation enable have no effect.
// - Internal clock with gate enable set selects gated accumulation mode.
// - Prescale field divides the selected clock by 1, 8, 64 or 256.
// - Concat select set in timer 0's control word joins both timers into one 32-bit timer.
// - Clock source set counts external pin rising edges, else peripheral clock.
// - Unimplemented control bits 14, 12..7, 2 and 0 read as zero.
module pgt_timer_pair #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Device and pins.
  input wire logic idle_mode,
  input wire logic [1:0] external_count_pin,
  input wire logic [1:0] gate_pin,
  // Period matches.
  output logic [1:0] period_match
);

  // --------------------------------------------------------------------------
  // Register slave
  // --------------------------------------------------------------------------
  logic [15:0] ctrl_r [2];
  logic [WIDTH-1:0] cnt_r [2];
  logic [WIDTH-1:0] per_r [2];
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [1:0] ext_s1_r, ext_s2_r, ext_s3_r, gate_s1_r, gate_s2_r;
  logic [7:0] pre_r [2];
  logic [1:0] match_r;

  wire access = hsel && hready && htrans[1];
  wire [31:0] rd_mux;
  wire [15:0] wr_ctrl = hwdata[15:0] & `PGT_CTRL_MASK;

  function automatic logic [7:0] div_limit(input logic [1:0] ps);
    case (pgt_pkg::pgt_prescale_t'(ps))
      pgt_pkg::PGT_PS_1: div_limit = 8'h00;
      pgt_pkg::PGT_PS_8: div_limit = `PGT_DIV8;
      pgt_pkg::PGT_PS_64: div_limit = `PGT_DIV64;
      pgt_pkg::PGT_PS_256: div_limit = `PGT_DIV256;
      default: div_limit = 8'h00;
    endcase
  endfunction

  assign rd_mux = (haddr == `PGT_OFS_CTRL_A) ? {16'h0000, ctrl_r[0]} :
                  (haddr == `PGT_OFS_CTRL_B) ? {16'h0000, ctrl_r[1]} :
                  (haddr == `PGT_OFS_TIMER_A) ? {16'h0000, cnt_r[0]} :
                  (haddr == `PGT_OFS_TIMER_B) ? {16'h0000, cnt_r[1]} :
                  (haddr == `PGT_OFS_PERIOD_A) ? {16'h0000, per_r[0]} :
                  (haddr == `PGT_OFS_PERIOD_B) ? {16'h0000, per_r[1]} : 32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign period_match = match_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_r <= access && hwrite;
      if (access) begin
        wr_addr_r <= haddr;
      end
      if (access && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_r <= 2'h0;
      ext_s2_r <= 2'h0;
      ext_s3_r <= 2'h0;
      gate_s1_r <= 2'h0;
      gate_s2_r <= 2'h0;
    end else begin
      ext_s1_r <= external_count_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      gate_s1_r <= gate_pin;
      gate_s2_r <= gate_s1_r;
    end
  end

  // --------------------------------------------------------------------------
  // Counting
  // --------------------------------------------------------------------------
  // Timer 1 follows timer 0's control word while the pair is joined, so its own settings are inert.
  wire concat = ctrl_r[0][`PGT_BIT_CONCAT];
  wire [15:0] eff_ctrl [2];
  wire [1:0] src_tick, gated, run_ok, pre_tick, step;
  assign eff_ctrl[0] = ctrl_r[0];
  assign eff_ctrl[1] = concat ? ctrl_r[0] : ctrl_r[1];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      wire [15:0] c = eff_ctrl[g];
      wire ext_edge = ext_s2_r[g] & ~ext_s3_r[g];
      // In 32-bit mode the first timer's pin drives the pair.
      wire ext_edge_sel = concat ? (ext_s2_r[0] & ~ext_s3_r[0]) : ext_edge;
      wire gate_lvl = concat ? gate_s2_r[0] : gate_s2_r[g];
      assign src_tick[g] = c[`PGT_BIT_CSRC] ? ext_edge_sel : 1'b1;
      assign gated[g] = ~c[`PGT_BIT_CSRC] & c[`PGT_BIT_GATE];
      assign run_ok[g] = c[`PGT_BIT_RUN] & ~(c[`PGT_BIT_IDLE_HALT] & idle_mode)
                         & (~gated[g] | gate_lvl);
      assign pre_tick[g] = run_ok[g] & src_tick[g] & (pre_r[g] == div_limit(c[`PGT_BIT_PS_HI:`PGT_BIT_PS_LO]));
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pre_r[g] <= 8'h00;
        end else if (wr_pend_r && wr_addr_r == (g ? `PGT_OFS_CTRL_B : `PGT_OFS_CTRL_A)) begin
          pre_r[g] <= 8'h00;
        end else if (run_ok[g] && src_tick[g]) begin
          pre_r[g] <= pre_tick[g] ? 8'h00 : pre_r[g] + 8'h01;
        end
      end
    end
  endgenerate

  wire [31:0] cnt32 = {cnt_r[1], cnt_r[0]};
  wire [31:0] per32 = {per_r[1], per_r[0]};
  wire hit32 = cnt32 == per32;
  assign step[0] = pre_tick[0];
  assign step[1] = concat ? 1'b0 : pre_tick[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        ctrl_r[i] <= `PGT_CTRL_RESET;
        cnt_r[i] <= '0;
        per_r[i] <= `PGT_PERIOD_RESET;
      end
      match_r <= 2'h0;
    end else begin
      match_r <= 2'h0;
      if (concat && step[0]) begin
        match_r <= {1'b0, hit32};
        {cnt_r[1], cnt_r[0]} <= hit32 ? 32'h0000_0000 : cnt32 + 32'h0000_0001;
      end else begin
        for (int i = 0; i < 2; i++) begin
          if (step[i] && !(concat && i == 1)) begin
            match_r[i] <= cnt_r[i] == per_r[i];
            cnt_r[i] <= (cnt_r[i] == per_r[i]) ? '0 : cnt_r[i] + 1'b1;
          end
        end
      end
      if (wr_pend_r) begin
        case (wr_addr_r)
          `PGT_OFS_CTRL_A: ctrl_r[0] <= wr_ctrl;
          `PGT_OFS_CTRL_B: ctrl_r[1] <= wr_ctrl;
          `PGT_OFS_TIMER_A: cnt_r[0] <= hwdata[WIDTH-1:0];
          `PGT_OFS_TIMER_B: cnt_r[1] <= hwdata[WIDTH-1:0];
          `PGT_OFS_PERIOD_A: per_r[0] <= hwdata[WIDTH-1:0];
          `PGT_OFS_PERIOD_B: per_r[1] <= hwdata[WIDTH-1:0];
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_unimpl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_r[0] & ~`PGT_CTRL_MASK) == 16'h0000) else $error("Unimplemented control bit set.");
  a_stop_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_r[0][`PGT_BIT_RUN] && !wr_pend_r |=> $stable(cnt_r[0])) else $error("Stopped timer moved.");
  a_idle_halt: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_r[0][`PGT_BIT_IDLE_HALT] && idle_mode |-> !pre_tick[0]) else $error("Counted in idle.");
  a_gate_low: assert property (@(posedge hclk) disable iff (!hresetn)
    gated[0] && !gate_s2_r[0] |-> !pre_tick[0]) else $error("Gated timer counted with gate low.");
  a_ext_ignores: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_r[0][`PGT_BIT_CSRC] |-> !gated[0]) else $error("Gate honoured on external clock.");
  a_ext_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_r[0][`PGT_BIT_CSRC] && !(ext_s2_r[0] && !ext_s3_r[0]) |-> !pre_tick[0])
    else $error("External timer counted without edge.");
  a_pair_idle_b: assert property (@(posedge hclk) disable iff (!hresetn)
    concat |-> !step[1]) else $error("Partner stepped alone in 32-bit mode.");
  a_partner_inert: assert property (@(posedge hclk) disable iff (!hresetn)
    concat |-> eff_ctrl[1] == ctrl_r[0]) else $error("Partner control used in 32-bit mode.");
  a_div_one: assert property (@(posedge hclk) disable iff (!hresetn)
    run_ok[0] && !ctrl_r[0][`PGT_BIT_CSRC] && ctrl_r[0][5:4] == 2'b00 |-> pre_tick[0])
    else $error("Prescale 1:1 missed a tick.");
  a_run32: assert property (@(posedge hclk) disable iff (!hresetn)
    concat && pre_tick[0] && !hit32 && !wr_pend_r |=> {cnt_r[1], cnt_r[0]} == $past(cnt32) + 32'h0000_0001)
    else $error("Pair counter did not advance.");
  a_gated_on: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_r[0][`PGT_BIT_CSRC] && ctrl_r[0][`PGT_BIT_GATE] |-> gated[0]) else $error("Gate mode not entered.");
endmodule

// ---- tb/pgt_pin_model.sv ----
// Behavioural model of the external count and gate pins that face the paired timer.
module pgt_pin_model (
  // Clock.
  input wire logic hclk,
  // Controls from the bench.
  input wire logic [1:0] ext_en,
  input wire logic [1:0] gate_lvl,
  // Pins toward the timer.
  output logic [1:0] external_count_pin,
  output logic [1:0] gate_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] tick_r = 3'h0;
  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  // The count pin stands low between bursts, so no stray edge is ever counted.
  always @(posedge hclk) begin
    tick_r <= tick_r + 3'h1;
  end
  assign external_count_pin = ext_en & {2{tick_r[2]}};
  assign gate_pin = gate_lvl;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking testbench for the paired timer control.
`include "pgt_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, idle_mode;
  logic [11:0] haddr;
  logic [1:0] htrans, ext_en, gate_lvl, ext_pin, gate_pin, match;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic hreadyout, hresp;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_match0 = 0;
  assign hready = hreadyout;
  // Match pulses are registered, so they are counted half a cycle after the edge that launches them.
  always @(negedge hclk) begin
    if (match[0] === 1'b1) begin
      n_match0++;
    end
  end
  pgt_timer_pair i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .idle_mode(idle_mode), .external_count_pin(ext_pin),
    .gate_pin(gate_pin), .period_match(match));
  pgt_pin_model i_pins (.hclk(hclk), .ext_en(ext_en), .gate_lvl(gate_lvl), .external_count_pin(ext_pin),
    .gate_pin(gate_pin));
  // ---------------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------------
  // A stuck slave is left to the watchdog, which turns the hang into a mismatch.
  task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, w};
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    {htrans, hwdata} <= {2'h0, d};
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Runs one timer setting for 512 cycles, stops it and checks the count window.
  task automatic run_case(input logic [15:0] ctrl, input logic [15:0] pre, input logic [11:0] a,
    input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] r1, r2;
    wr(`PGT_OFS_TIMER_A, {16'h0, pre});
    wr(`PGT_OFS_TIMER_B, 32'h0);
    wr(`PGT_OFS_CTRL_A, {16'h0, ctrl});
    repeat (512) @(posedge hclk);
    wr(`PGT_OFS_CTRL_A, {16'h0, ctrl & 16'h7FFF});
    ahb(a, 1'b0, 32'h0, r1);
    repeat (20) @(posedge hclk);
    ahb(a, 1'b0, 32'h0, r2);
    check({31'h0, (r1 >= lo) && (r1 <= hi)}, 32'h1);
    check(r2, r1);
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Clock, reset and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    complete_run();
  end
  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    int dv[4];
    dv = '{1, 8, 64, 256};
    {hresetn, hsel, hwrite, idle_mode, haddr, htrans, hsize, hwdata} = '0;
    {ext_en, gate_lvl} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(`PGT_OFS_CTRL_A, 1'b0, 32'h0, q);
    check(q, {16'h0, `PGT_CTRL_RESET});
    check({31'h0, hresp}, 32'h0);
    ahb(`PGT_OFS_PERIOD_A, 1'b0, 32'h0, q);
    check(q, {16'h0, `PGT_PERIOD_RESET});
    wr(`PGT_OFS_CTRL_B, 32'h0000FFFF);
    ahb(`PGT_OFS_CTRL_B, 1'b0, 32'h0, q);
    check(q, 32'h0000A07A);
    wr(`PGT_OFS_CTRL_B, 32'h0);
    wr(12'h020, 32'hFFFFFFFF);
    ahb(12'h020, 1'b0, 32'h0, q);
    check(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      run_case({10'h200, i[1:0], 4'h0}, 16'h0, `PGT_OFS_TIMER_A, 32'(512 / dv[i] - 1), 32'(520 / dv[i] + 1));
    end
    idle_mode <= 1'b1;
    run_case(16'hA000, 16'h0, `PGT_OFS_TIMER_A, 32'h0, 32'h0);
    run_case(16'h8000, 16'h0, `PGT_OFS_TIMER_A, 32'd511, 32'd521);
    idle_mode <= 1'b0;
    run_case(16'h8040, 16'h0, `PGT_OFS_TIMER_A, 32'h0, 32'h0);
    gate_lvl <= 2'h1;
    run_case(16'h8040, 16'h0, `PGT_OFS_TIMER_A, 32'd511, 32'd521);
    gate_lvl <= 2'h0;
    run_case(16'h8042, 16'h0, `PGT_OFS_TIMER_A, 32'h0, 32'h0);
    ext_en <= 2'h1;
    run_case(16'h8042, 16'h0, `PGT_OFS_TIMER_A, 32'd61, 32'd68);
    ext_en <= 2'h0;
    run_case(16'h8000, 16'hFFF0, `PGT_OFS_TIMER_B, 32'h0, 32'h0);
    run_case(16'h8008, 16'hFFF0, `PGT_OFS_TIMER_B, 32'h1, 32'h1);
    wr(`PGT_OFS_PERIOD_A, 32'h9);
    n_match0 = 0;
    run_case(16'h8000, 16'h0, `PGT_OFS_TIMER_A, 32'h4, 32'h4);
    check(32'(n_match0), 32'd51);
    complete_run();
  end
endmodule
